// >>> hw/half_counter.sv
// Purpose: clear-on-read ten-bit event counter with half-way flag
// Assumes: inc and clr on mclk
// Notes:   wraps past 3ff
`include "txbuf_consts.svh"
`timescale 1ns/100ps
module half_counter #(
  parameter int WIDTH = 10
) (
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic             inc,
  input  wire logic             clr,
  output logic      [WIDTH-1:0] count,
  output logic                  half
);
  typedef struct packed {
    logic [WIDTH-1:0] cnt;
  } st_t;
  st_t st_q;
  st_t st_d;

  always_comb begin
    st_d = st_q;
    if (clr) begin
      st_d.cnt = inc ? WIDTH'(1) : '0;  // a count arriving with the read is kept
    end else if (inc) begin
      st_d.cnt = st_q.cnt + WIDTH'(1);  // [R23]
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign count = st_q.cnt;
  assign half  = inc && !clr && (st_q.cnt == WIDTH'(`COUNT_HALF));  // [R19] [R20]
endmodule // half_counter

// >>> hw/tx_buffer_events.sv
// Purpose: transmit command register, buffer interrupt enables, buffer events
// Assumes: one 40 MHz clock, synchronous active-high reset, plain register port
// Notes:   all event and counter registers clear on read
//
// Summary of operation
// R1 - transmit command status reads id 001001 in bits 5..0.
// R2 - a write to 144h starts transmission; latest command readable at 108h.
// R3 - start threshold selects 5, 381, 1021 bytes or whole frame.
// R4 - purge drops queued frames; running frame cut within 64 bit times, bad crc.
// R5 - one-collision flag aborts after first collision, else after 16.
// R6 - crc suppress sends frame without fcs.
// R7 - pad enabled pads short frames to 60 bytes, then fcs unless suppressed.
// R8 - pad disabled sends runts unpadded, fcs per suppress flag.
// R9 - transmit length below 3 bytes is refused.
// R10 - reset values hold only identifier bits; eeprom may load instead.
// R11 - soft irq request sets soft irq event once per written 1.
// R12 - each enable bit gates one buffer event onto the interrupt.
// R13 - dma frame event set when received frames moved by slave dma.
// R14 - transmit accept event set when a frame can be accepted.
// R15 - underrun sets starve event and abandons frame; host must resend.
// R16 - receive loss sets lost event and bumps the lost frame counter.
// R17 - early receive event set after first 128 bytes arrive.
// R18 - host keeps early receive enables clear in dma or streaming modes.
// R19 - collision counter counts; interrupt on step 1ff to 200 if enabled.
// R20 - lost counter interrupt on step 1ff to 200 if enabled.
// R21 - address match event set first; after 128 bytes becomes early receive.
// R22 - reading buffer event returns id and clears all event bits.
// R23 - counters sit in upper ten bits, wrap past 3ff, clear on read.
// R24 - interrupt asserted while any event and its enable are both set.
//
// Design decision made here: the address-and-strobe port.
`include "txbuf_consts.svh"
`timescale 1ns/100ps
module tx_buffer_events
  import txbuf_pkg::*;
(
  input  wire logic            mclk,
  input  wire logic            rst,
  input  txbuf_pkg::reg_req_t  req,
  output logic [15:0]          rdata,
  input  txbuf_pkg::mac_evt_t  mac_evt,
  input  wire logic            eeprom_load,
  input  wire logic [15:0]     eeprom_tx_cmd,
  input  wire logic [15:0]     eeprom_irq_en,
  input  wire logic [10:0]     transmit_length,
  input  wire logic [10:0]     bytes_buffered,
  input  wire logic            frame_sent,
  output logic                 tx_go,
  output logic                 tx_abort,
  output logic                 tx_drop_queue,
  output logic                 tx_bad_fcs,
  output logic                 tx_append_fcs,
  output logic [10:0]          tx_frame_len,
  output logic                 tx_refused,
  output logic                 irq
);
  import txbuf_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [15:0] tx_cmd;
    logic [15:0] irq_en;
    logic [15:0] events;
    logic [10:0] rx_bytes;
    logic        cmd_new;
    logic [15:0] rdata;
  } st_t;
  st_t st_q;
  st_t st_d;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  logic        wr_cmd;
  logic        wr_en;
  logic        rd_evt;
  logic        rd_lost;
  logic        rd_coll;
  logic [9:0]  lost_count;
  logic [9:0]  coll_count;
  logic        lost_half;
  logic        coll_half;
  logic        early_hit;
  logic [15:0] set_mask;
  tx_cmd_t     cmd;

  assign wr_cmd  = req.wr && req.addr == `OFS_TX_COMMAND;  // [R2]
  assign wr_en   = req.wr && req.addr == `OFS_BUF_IRQ_EN;
  assign rd_evt  = req.rd && req.addr == `OFS_BUF_EVENT;
  assign rd_lost = req.rd && req.addr == `OFS_LOST_COUNT;
  assign rd_coll = req.rd && req.addr == `OFS_COLL_COUNT;

  assign cmd.start_threshold = st_q.tx_cmd[7:6];
  assign cmd.purge           = st_q.tx_cmd[`BIT_PURGE];
  assign cmd.one_coll        = st_q.tx_cmd[`BIT_ONE_COLL];
  assign cmd.fcs_suppress    = st_q.tx_cmd[`BIT_FCS_SUPPRESS];
  assign cmd.pad_disable     = st_q.tx_cmd[`BIT_PAD_DISABLE];

  assign early_hit = mac_evt.rx_byte && st_q.rx_bytes == `EARLY_RX_BYTES - 11'd1;

  // ----------------------------------------
  // counters
  // ----------------------------------------
  half_counter #(
    .WIDTH (10)
  ) u_lost (
    .mclk  (mclk),
    .rst   (rst),
    .inc   (mac_evt.rx_lost),  // [R16]
    .clr   (rd_lost),  // [R23]
    .count (lost_count),
    .half  (lost_half)
  );

  half_counter #(
    .WIDTH (10)
  ) u_coll (
    .mclk  (mclk),
    .rst   (rst),
    .inc   (mac_evt.collision),  // [R19]
    .clr   (rd_coll),  // [R23]
    .count (coll_count),
    .half  (coll_half)
  );

  // ----------------------------------------
  // event set sources
  // ----------------------------------------
  always_comb begin
    set_mask                  = '0;
    set_mask[`BIT_SOFT_IRQ]   = wr_en && req.wdata[`BIT_SOFT_IRQ];  // [R11]
    set_mask[`BIT_DMA_FRAME]  = mac_evt.dma_frame_done;  // [R13]
    set_mask[`BIT_TX_ACCEPT]  = mac_evt.tx_accept;  // [R14]
    set_mask[`BIT_TX_STARVE]  = mac_evt.tx_starve;  // [R15]
    set_mask[`BIT_RX_LOST]    = mac_evt.rx_lost;  // [R16]
    set_mask[`BIT_EARLY_RX]   = early_hit;  // [R17]
    // half-way steps live in enable positions; they share the event word
    set_mask[`BIT_COLL_HALF]  = coll_half;  // [R19]
    set_mask[`BIT_LOST_HALF]  = lost_half;  // [R20]
    set_mask[`BIT_ADDR_MATCH] = mac_evt.addr_match;  // [R21]
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    st_d         = st_q;
    st_d.cmd_new = wr_cmd;
    if (wr_cmd) begin
      st_d.tx_cmd = {req.wdata[15:6], `ID_TX_CMD};  // [R2] [R1]
    end
    if (wr_en) begin
      // soft request acts once, never stored
      st_d.irq_en = {req.wdata[15:7], 1'b0, `ID_BUF_IRQ_EN};  // [R11]
    end
    if (rd_evt) begin
      st_d.events = '0;  // [R22]
    end
    st_d.events = st_d.events | set_mask;  // set wins over a clearing read
    if (early_hit) begin
      st_d.events[`BIT_ADDR_MATCH] = 1'b0;  // [R21]
    end
    if (mac_evt.rx_frame_start) begin
      st_d.rx_bytes = '0;
    end else if (mac_evt.rx_byte && st_q.rx_bytes != 11'h7ff) begin
      st_d.rx_bytes = st_q.rx_bytes + 11'd1;
    end
    unique case (1'b1)
      req.rd && req.addr == `OFS_TX_CMD_STATUS: st_d.rdata = st_q.tx_cmd;  // [R2]
      req.rd && req.addr == `OFS_BUF_IRQ_EN:    st_d.rdata = st_q.irq_en;
      rd_evt:  st_d.rdata = {st_q.events[15:6], `ID_BUF_EVENT};  // [R22]
      rd_lost: st_d.rdata = {lost_count, `ID_LOST_COUNT};  // [R23]
      rd_coll: st_d.rdata = {coll_count, `ID_COLL_COUNT};  // [R23]
      default: st_d.rdata = 16'h0000;
    endcase
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_q <= '{tx_cmd: `RST_TX_CMD, irq_en: `RST_BUF_IRQ_EN, events: 16'h0000,
                rx_bytes: 11'h000, cmd_new: 1'b0, rdata: 16'h0000};  // [R10]
    end else if (eeprom_load) begin
      st_q        <= st_d;
      st_q.tx_cmd <= {eeprom_tx_cmd[15:6], `ID_TX_CMD};  // [R10]
      st_q.irq_en <= {eeprom_irq_en[15:7], 1'b0, `ID_BUF_IRQ_EN};  // [R10]
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------
  // transmit control
  // ----------------------------------------
  tx_gate u_gate (
    .mclk            (mclk),
    .rst             (rst),
    .cmd             (cmd),
    .cmd_new         (st_q.cmd_new),  // [R2]
    .transmit_length (transmit_length),
    .bytes_buffered  (bytes_buffered),
    .frame_sent      (frame_sent),
    .collision       (mac_evt.collision),
    .tx_starve       (mac_evt.tx_starve),
    .tx_go           (tx_go),
    .tx_abort        (tx_abort),
    .tx_drop_queue   (tx_drop_queue),
    .tx_bad_fcs      (tx_bad_fcs),
    .tx_append_fcs   (tx_append_fcs),
    .tx_frame_len    (tx_frame_len),
    .tx_refused      (tx_refused)
  );

  assign rdata = st_q.rdata;
  // early receive enable trusted to be clear in dma modes
  assign irq   = |(st_q.events[15:6] & st_q.irq_en[15:6]
                   | {9'h000, st_q.events[`BIT_SOFT_IRQ]});  // [R24] [R12] [R18]
endmodule // tx_buffer_events

// >>> hw/tx_gate.sv
// Purpose: decides start, length handling and abort of one transmit frame
// Assumes: byte counts come from the transmit buffer logic
// Notes:   the serialiser itself lives elsewhere
`include "txbuf_consts.svh"
`timescale 1ns/100ps
module tx_gate
  import txbuf_pkg::*;
(
  input  wire logic            mclk,
  input  wire logic            rst,
  input  txbuf_pkg::tx_cmd_t   cmd,
  input  wire logic            cmd_new,
  input  wire logic [10:0]     transmit_length,
  input  wire logic [10:0]     bytes_buffered,
  input  wire logic            frame_sent,
  input  wire logic            collision,
  input  wire logic            tx_starve,
  output logic                 tx_go,
  output logic                 tx_abort,
  output logic                 tx_drop_queue,
  output logic                 tx_bad_fcs,
  output logic                 tx_append_fcs,
  output logic [10:0]          tx_frame_len,
  output logic                 tx_refused
);
  localparam logic [8:0] PURGE_CYC = 9'(`PURGE_CYCLES);
  typedef struct packed {
    tx_state_t  state;
    logic [4:0] colls;
    logic [8:0] cut;
    logic       go;
    logic       abort;
    logic       bad_fcs;
    logic       refused;
  } st_t;
  st_t        st_q;
  st_t        st_d;
  logic [10:0] need;

  always_comb begin
    unique case (cmd.start_threshold)  // [R3]
      2'b00: need = `THRESH_0;
      2'b01: need = `THRESH_1;
      2'b10: need = `THRESH_2;
      2'b11: need = transmit_length;
    endcase
  end

  always_comb begin
    st_d         = st_q;
    st_d.go      = 1'b0;
    st_d.abort   = 1'b0;
    st_d.refused = 1'b0;
    unique case (st_q.state)
      TX_IDLE: begin
        if (cmd_new) begin
          if (transmit_length < `MIN_TX_LEN) begin
            st_d.refused = 1'b1;  // [R9]
          end else begin
            st_d.state   = TX_ARMED;
            st_d.colls   = '0;
            st_d.bad_fcs = 1'b0;
          end
        end
      end
      TX_ARMED: begin
        if (cmd_new && cmd.purge) begin
          st_d.state = TX_IDLE;  // [R4]
        end else if (bytes_buffered >= need || bytes_buffered >= transmit_length) begin
          st_d.state = TX_SEND;
          st_d.go    = 1'b1;
        end
      end
      TX_SEND: begin
        if (cmd_new && cmd.purge) begin
          st_d.state   = TX_ABORT;  // [R4]
          st_d.cut     = PURGE_CYC;
          st_d.bad_fcs = 1'b1;
        end else if (tx_starve) begin
          st_d.state = TX_IDLE;  // [R15]
          st_d.abort = 1'b1;
        end else if (collision) begin
          st_d.colls = st_q.colls + 5'd1;
          if (cmd.one_coll || st_q.colls + 5'd1 >= `MAX_COLL_TRIES) begin
            st_d.state = TX_IDLE;  // [R5]
            st_d.abort = 1'b1;
          end
        end else if (frame_sent) begin
          st_d.state = TX_IDLE;
        end
      end
      TX_ABORT: begin
        // cut after PURGE_CYCLES, the full 64 allowed bit times, or earlier at frame_sent
        st_d.cut = st_q.cut - 9'd1;
        if (st_q.cut <= 9'd1 || frame_sent) begin
          st_d.state = TX_IDLE;
          st_d.abort = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st_q <= '{state: TX_IDLE, colls: 5'd0, cut: 9'd0, go: 1'b0, abort: 1'b0,
                bad_fcs: 1'b0, refused: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  assign tx_go         = st_q.go;
  assign tx_abort      = st_q.abort;
  assign tx_refused    = st_q.refused;
  assign tx_bad_fcs    = st_q.bad_fcs;
  assign tx_drop_queue = cmd_new && cmd.purge;  // [R4]
  assign tx_append_fcs = !cmd.fcs_suppress;  // [R6] [R7] [R8]
  assign tx_frame_len  = (!cmd.pad_disable && transmit_length < `PAD_LEN)
                         ? `PAD_LEN : transmit_length;  // [R7] [R8]
endmodule // tx_gate

// >>> hw/txbuf_consts.svh
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 16-bit registers on a plain strobe port
// Notes:   definitions only
`ifndef TXBUF_CONSTS_SVH
`define TXBUF_CONSTS_SVH
`define OFS_TX_COMMAND        12'h144
`define OFS_TX_CMD_STATUS     12'h108
`define OFS_BUF_IRQ_EN        12'h10a
`define OFS_BUF_EVENT         12'h12c
`define OFS_LOST_COUNT        12'h130
`define OFS_COLL_COUNT        12'h132
`define ID_TX_CMD             6'h09
`define ID_BUF_IRQ_EN         6'h0b
`define ID_BUF_EVENT          6'h0c
`define ID_LOST_COUNT         6'h10
`define ID_COLL_COUNT         6'h12
`define RST_TX_CMD            16'h0009
`define RST_BUF_IRQ_EN        16'h000b
`define BIT_SOFT_IRQ          6
`define BIT_DMA_FRAME         7
`define BIT_TX_ACCEPT         8
`define BIT_TX_STARVE         9
`define BIT_RX_LOST           10
`define BIT_EARLY_RX          11
`define BIT_COLL_HALF         12
`define BIT_LOST_HALF         13
`define BIT_ADDR_MATCH        15
`define BIT_PURGE             8
`define BIT_ONE_COLL          9
`define BIT_FCS_SUPPRESS      12
`define BIT_PAD_DISABLE       13
`define THRESH_0              11'd5
`define THRESH_1              11'd381
`define THRESH_2              11'd1021
`define MIN_TX_LEN            11'd3
`define PAD_LEN               11'd60
`define MAX_COLL_TRIES        5'd16
`define PURGE_BIT_TIMES       64
`define BIT_TIME_NS           100
`define CLK_NS                25
`define PURGE_CYCLES          ((`PURGE_BIT_TIMES * `BIT_TIME_NS) / `CLK_NS)
`define EARLY_RX_BYTES        11'd128
`define COUNT_HALF            10'h1ff
`endif

// >>> hw/txbuf_pkg.sv
// Purpose: types shared by the buffer event block
// Assumes: nothing
// Notes:   constants live in txbuf_consts.svh
package txbuf_pkg;
  typedef struct packed {
    logic [11:0] addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;

  typedef struct packed {
    logic dma_frame_done;
    logic tx_accept;
    logic tx_starve;
    logic rx_lost;
    logic addr_match;
    logic rx_byte;
    logic rx_frame_start;
    logic collision;
  } mac_evt_t;

  typedef struct packed {
    logic [1:0]  start_threshold;
    logic        purge;
    logic        one_coll;
    logic        fcs_suppress;
    logic        pad_disable;
  } tx_cmd_t;

  typedef enum logic [1:0] {
    TX_IDLE  = 2'b00,
    TX_ARMED = 2'b01,
    TX_SEND  = 2'b10,
    TX_ABORT = 2'b11
  } tx_state_t;
endpackage

// >>> verif/host_model.sv
// Purpose: host side of the plain register port
// Assumes: strobes one cycle, read data the cycle after rd
// Notes:   tasks are called from the bench
`timescale 1ns/100ps
module host_model
  import txbuf_pkg::*;
(
  input  wire logic           mclk,
  output txbuf_pkg::reg_req_t req,
  input  wire logic [15:0]    rdata
);
  import txbuf_pkg::*;
  initial req = '0;
  // host starts a frame only by writing 144h
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    @(posedge mclk);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge mclk);
    req.wr <= 1'b0;
  endtask
  // one read sees every event; caller handles all bits
  task automatic rd(input logic [11:0] a, output logic [15:0] d);
    @(posedge mclk);
    req <= '{a, 16'h0, 1'b0, 1'b1};
    @(posedge mclk);
    req.rd <= 1'b0;
    #1 d = rdata;
  endtask
endmodule // host_model

// >>> verif/test_tx_buffer_events.sv
// Purpose: self-checking bench for the buffer event block
// Assumes: 40 MHz mclk, eeprom load driven only in the last scenario
// Notes:   counters need 512 pulses each, so run is a few thousand cycles
`timescale 1ns/100ps
module test_tx_buffer_events;
  import txbuf_pkg::*;
  logic mclk, rst, frame_sent, tx_go, tx_abort, tx_drop_queue, tx_bad_fcs;
  logic tx_append_fcs, tx_refused, irq;
  logic eeprom_load;
  logic [15:0] ee_cmd, ee_en;
  logic [10:0] transmit_length, bytes_buffered, tx_frame_len;
  logic [15:0] rdata, v;
  reg_req_t req;
  mac_evt_t mac_evt;
  int n_mismatch = 0, tests_run = 0, cyc = 0, n_go = 0, n_ref = 0, n_drop = 0, n_abt = 0;
  host_model i_host_model (.mclk(mclk), .req(req), .rdata(rdata));
  tx_buffer_events i_tx_buffer_events (.mclk(mclk), .rst(rst), .req(req), .rdata(rdata),
    .mac_evt(mac_evt), .eeprom_load(eeprom_load), .eeprom_tx_cmd(ee_cmd), .eeprom_irq_en(ee_en),
    .transmit_length(transmit_length), .bytes_buffered(bytes_buffered),
    .frame_sent(frame_sent), .tx_go(tx_go), .tx_abort(tx_abort),
    .tx_drop_queue(tx_drop_queue), .tx_bad_fcs(tx_bad_fcs), .tx_append_fcs(tx_append_fcs),
    .tx_frame_len(tx_frame_len), .tx_refused(tx_refused), .irq(irq));
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  always @(posedge mclk) begin
    cyc++;
    n_go += (tx_go === 1'b1);
    n_ref += (tx_refused === 1'b1);
    n_drop += (tx_drop_queue === 1'b1);
    n_abt += (tx_abort === 1'b1);
    if (cyc == 20000) begin
      n_mismatch++;
      conclude();
    end
  end
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic ev(input int b, input int n);
    repeat (n) begin
      @(posedge mclk);
      mac_evt[b] <= 1'b1;
      @(posedge mclk);
      mac_evt[b] <= 1'b0;
    end
  endtask
  task automatic sent();
    @(posedge mclk);
    frame_sent <= 1'b1;
    @(posedge mclk);
    frame_sent <= 1'b0;
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic test_reset();
    i_host_model.rd(12'h108, v); chk("cmd", v, 16'h0009);
    i_host_model.rd(12'h10a, v); chk("en", v, 16'h000b);
    i_host_model.rd(12'h12c, v); chk("evt", v, 16'h000c);
    i_host_model.rd(12'h100, v); chk("unmapped", v, 16'h0000);
    $display("test_reset done");
  endtask
  task automatic test_soft();
    i_host_model.wr(12'h10a, 16'h0040);
    #1 chk("irq", {15'h0, irq}, 16'h1);
    i_host_model.rd(12'h12c, v); chk("evt", v, 16'h004c);
    i_host_model.rd(12'h12c, v); chk("evt2", v, 16'h000c);
    i_host_model.rd(12'h10a, v); chk("en", v, 16'h000b);
    $display("test_soft done");
  endtask
  task automatic test_events();
    int src[5] = '{7, 6, 5, 4, 3};
    int pos[5] = '{7, 8, 9, 10, 15};
    for (int i = 0; i < 5; i++) begin
      for (int e = 0; e < 2; e++) begin
        i_host_model.wr(12'h10a, e ? 16'hbf80 : 16'h0000);  // no dma modes here
        ev(src[i], 1);
        repeat (2) @(posedge mclk);
        chk("irq", {15'h0, irq}, 16'(e));
        i_host_model.rd(12'h12c, v);
        chk("evt", v, 16'h000c | (16'h1 << pos[i]));
        chk("irq_rel", {15'h0, irq}, 16'h0);
      end
    end
    $display("test_events done");
  endtask
  task automatic test_early();
    ev(1, 1);
    ev(3, 1);
    ev(2, 127);
    i_host_model.rd(12'h12c, v); chk("127", v, 16'h800c);
    ev(3, 1);
    ev(2, 1);
    i_host_model.rd(12'h12c, v); chk("128", v, 16'h080c);
    $display("test_early done");
  endtask
  task automatic test_counters();
    int src[2] = '{4, 0};
    logic [15:0] evx[2] = '{16'h240c, 16'h100c};
    logic [11:0] adr[2] = '{12'h130, 12'h132};
    logic [15:0] idv[2] = '{16'h0010, 16'h0012};
    i_host_model.wr(12'h10a, 16'h3000);
    for (int i = 0; i < 2; i++) begin
      // test_events left lost counts behind; a read empties the counter
      i_host_model.rd(adr[i], v);
      ev(src[i], 511);
      i_host_model.rd(12'h12c, v);
      chk("no_half", {15'h0, irq}, 16'h0);
      ev(src[i], 1);
      repeat (2) @(posedge mclk);
      chk("half_irq", {15'h0, irq}, 16'h1);
      i_host_model.rd(12'h12c, v); chk("evt", v, evx[i]);
      i_host_model.rd(adr[i], v); chk("count", v, 16'h8000 | idv[i]);
      i_host_model.rd(adr[i], v); chk("cleared", v, idv[i]);
    end
    $display("test_counters done");
  endtask
  task automatic test_threshold();
    int thr[4] = '{5, 381, 1021, 1500};
    int g;
    transmit_length <= 11'd1500;
    for (int k = 0; k < 4; k++) begin
      bytes_buffered <= 11'(thr[k] - 1);
      g = n_go;
      i_host_model.wr(12'h144, 16'(k) << 6);
      i_host_model.rd(12'h108, v); chk("cmd", v, (16'(k) << 6) | 16'h0009);
      repeat (6) @(posedge mclk);
      chk("early_go", 16'(n_go), 16'(g));
      bytes_buffered <= 11'(thr[k]);
      repeat (6) @(posedge mclk);
      chk("go", 16'(n_go), 16'(g + 1));
      sent();
    end
    $display("test_threshold done");
  endtask
  task automatic test_frame();
    int g;
    transmit_length <= 11'd40;
    i_host_model.wr(12'h144, 16'h0000);
    i_host_model.rd(12'h108, v);
    chk("len", {5'h0, tx_frame_len}, 16'd60);
    chk("fcs", {15'h0, tx_append_fcs}, 16'h1);
    sent();
    i_host_model.wr(12'h144, 16'h3000);
    i_host_model.rd(12'h108, v);
    chk("runt", {5'h0, tx_frame_len}, 16'd40);
    chk("nofcs", {15'h0, tx_append_fcs}, 16'h0);
    sent();
    transmit_length <= 11'd2;
    g = n_go;
    i_host_model.wr(12'h144, 16'h0100);
    repeat (6) @(posedge mclk);
    chk("refused", 16'(n_ref), 16'h1);
    chk("nogo", 16'(n_go), 16'(g));
    chk("drop", 16'(n_drop), 16'h1);
    $display("test_frame done");
  endtask
  task automatic test_abort();
    int a;
    transmit_length <= 11'd100;
    for (int k = 0; k < 4; k++) begin
      a = n_abt;
      i_host_model.wr(12'h144, (k == 0) ? 16'h0200 : 16'h0000);
      repeat (4) @(posedge mclk);
      if (k == 1) begin
        ev(0, 15);
        repeat (2) @(posedge mclk);
        chk("retry", 16'(n_abt), 16'(a));
      end
      if (k < 2) ev(0, 1);
      if (k == 2) ev(5, 1);
      if (k == 3) begin
        i_host_model.wr(12'h144, 16'h0100);
        repeat (2) @(posedge mclk);
        chk("bad_fcs", {15'h0, tx_bad_fcs}, 16'h1);
      end
      repeat (260) @(posedge mclk);
      chk("abort", 16'(n_abt), 16'(a + 1));
    end
    $display("test_abort done");
  endtask
  task automatic test_eeprom();
    @(posedge mclk);
    eeprom_load <= 1'b1;
    @(posedge mclk);
    eeprom_load <= 1'b0;
    i_host_model.rd(12'h108, v); chk("ee_cmd", v, 16'h3fc9);
    i_host_model.rd(12'h10a, v); chk("ee_en", v, 16'hff8b);
    $display("test_eeprom done");
  endtask
  initial begin
    rst = 1'b1;
    frame_sent = 1'b0;
    mac_evt = '0;
    transmit_length = 11'd1500;
    bytes_buffered = 11'd0;
    eeprom_load = 1'b0;
    ee_cmd = 16'h3fff;
    ee_en = 16'hffff;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    test_reset();
    test_soft();
    test_events();
    test_early();
    test_counters();
    test_threshold();
    test_frame();
    test_abort();
    test_eeprom();
    conclude();
  end
endmodule // test_tx_buffer_events

// >>> verif/tx_buffer_events_checker.sv
// Purpose: port assertions for the buffer event block
// Assumes: single clock, sync reset
// Notes:   bound to every instance
`timescale 1ns/100ps
module tx_buffer_events_checker
  import txbuf_pkg::*;
(
  input  wire logic           mclk,
  input  wire logic           rst,
  input  txbuf_pkg::reg_req_t req,
  input  wire logic [15:0]    rdata,
  input  txbuf_pkg::mac_evt_t mac_evt,
  input  wire logic [10:0]    transmit_length,
  input  wire logic           tx_drop_queue,
  input  wire logic           tx_append_fcs,
  input  wire logic [10:0]    tx_frame_len,
  input  wire logic           tx_refused,
  input  wire logic           irq
);
  import txbuf_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_rd_evt; req.rd && req.addr == 12'h12c; endsequence
  sequence s_rd_cmd; req.rd && req.addr == 12'h108; endsequence
  sequence s_wr_cmd; req.wr && req.addr == 12'h144; endsequence
  sequence s_quiet; mac_evt == '0 && !req.wr; endsequence
  AST_ID_CMD: assert property (s_rd_cmd |=> rdata[5:0] == 6'h09)
    else $error("command id bits wrong");
  AST_ID_EVT: assert property (s_rd_evt |=> rdata[5:0] == 6'h0c)
    else $error("event id bits wrong");
  AST_EVT_CLR: assert property ((s_rd_evt and s_quiet) ##1 s_quiet ##1 s_rd_evt
    |=> rdata[15:6] == '0) else $error("events not cleared by read");
  AST_IRQ_REL: assert property ((s_rd_evt and s_quiet) |=> !irq)
    else $error("irq held after clearing read");
  AST_SOFT: assert property (req.wr && req.addr == 12'h10a && req.wdata[6] |=> irq)
    else $error("soft request gave no irq");
  AST_CMD: assert property (s_wr_cmd ##2 s_rd_cmd
    |=> (rdata & 16'h33c0) == ($past(req.wdata, 3) & 16'h33c0))
    else $error("command not mirrored");
  AST_REFUSE: assert property (s_wr_cmd and transmit_length < 11'd3 |-> ##2 tx_refused)
    else $error("short frame not refused");
  AST_DROP: assert property (s_wr_cmd and req.wdata[8] |=> tx_drop_queue)
    else $error("purge did not drop queue");
  AST_FCS: assert property (s_wr_cmd |=> tx_append_fcs == !$past(req.wdata[12]))
    else $error("fcs append wrong");
  AST_PAD: assert property ((s_wr_cmd and !req.wdata[13]
    and transmit_length inside {[11'd3:11'd59]}) ##1 $stable(transmit_length)
    |-> tx_frame_len == 11'd60) else $error("short frame not padded");
endmodule // tx_buffer_events_checker
bind tx_buffer_events tx_buffer_events_checker i_tx_buffer_events_checker (
  .mclk(mclk), .rst(rst), .req(req), .rdata(rdata), .mac_evt(mac_evt),
  .transmit_length(transmit_length), .tx_drop_queue(tx_drop_queue),
  .tx_append_fcs(tx_append_fcs), .tx_frame_len(tx_frame_len),
  .tx_refused(tx_refused), .irq(irq));
